// ### logic/llr_defines.vh
`ifndef LLR_DEFINES_VH
`define LLR_DEFINES_VH

// ********************************************************************
// Clock and step interval times
// ********************************************************************
// Counts are in 8 ns clock cycles for 51 us, 13 ms, 26 ms and 52 ms.
// They are held as sized constants because the times in picoseconds overflow 32 bits.
`define LLR_STEP0_CYCLES 23'h0018E7
`define LLR_STEP1_CYCLES 23'h18CBA8
`define LLR_STEP2_CYCLES 23'h319750
`define LLR_STEP3_CYCLES 23'h632EA0
`define LLR_CNT_W 23

// ********************************************************************
// Ramp-rate selection codes, index is {ramp_rate_bit_a, ramp_rate_bit_b}
// ********************************************************************
`define LLR_RATE_51US 2'h0
`define LLR_RATE_13MS 2'h1
`define LLR_RATE_26MS 2'h2
`define LLR_RATE_52MS 2'h3

// ********************************************************************
// Level code and shared pin control fields
// ********************************************************************
`define LLR_CODE_W 5
`define LLR_CODE_ZERO 5'h00
`define LLR_PIN_EN_BIT 0
`define LLR_PIN_DIR_BIT 1
`define LLR_PIN_DATA_BIT 2
`define LLR_PIN_CTRL_RESET 8'h00

// ********************************************************************
// Layout of the captured host field vector
// ********************************************************************
`define LLR_HV_W 19
`define LLR_HV_RATE_LO 0
`define LLR_HV_PCODE_LO 2
`define LLR_HV_SCODE_LO 7
`define LLR_HV_PON 12
`define LLR_HV_SON 13
`define LLR_HV_UNI 14
`define LLR_HV_VMODE 15
`define LLR_HV_PIN_LO 16
`define LLR_HV_RESET 19'h00000

`endif

// ### logic/llr_ramp_channel.v
`timescale 1ns/10ps
`default_nettype none
`include "llr_defines.vh"

module llr_ramp_channel #(
  parameter CNT_W = `LLR_CNT_W
) (
  input wire clk,
  input wire arst_n,
  input wire clear,
  input wire sink_on,
  input wire [`LLR_CODE_W-1:0] target,
  input wire [CNT_W-1:0] step_limit,
  output reg [`LLR_CODE_W-1:0] level,
  output reg busy,
  output reg sink_hiz
);

  reg [`LLR_CODE_W-1:0] goal;
  reg [CNT_W-1:0] cnt;
  reg [`LLR_CODE_W-1:0] next_level;
  reg [`LLR_CODE_W-1:0] next_goal;
  reg [CNT_W-1:0] next_cnt;
  reg next_busy;
  wire [`LLR_CODE_W-1:0] desired;
  wire [`LLR_CODE_W-1:0] run_goal;
  wire interval_done;

  // Switching off always aims at zero, even in the middle of a ramp.
  assign desired = sink_on ? target : `LLR_CODE_ZERO;
  assign run_goal = sink_on ? goal : `LLR_CODE_ZERO;
  // Compared live against the current limit so a rate change acts at once.
  assign interval_done = (cnt >= step_limit - {{(CNT_W-1){1'b0}}, 1'b1});

  function [`LLR_CODE_W-1:0] step_toward;
    input [`LLR_CODE_W-1:0] cur;
    input [`LLR_CODE_W-1:0] aim;
    begin
      if (aim > cur) begin
        step_toward = cur + 5'h01;
      end else if (aim < cur) begin
        step_toward = cur - 5'h01;
      end else begin
        step_toward = cur;
      end
    end
  endfunction

  always @* begin
    next_level = level;
    next_goal = goal;
    next_cnt = cnt;
    next_busy = busy;
    if (!busy) begin
      if (desired != level) begin
        // The first code of a ramp is taken without waiting an interval.
        next_goal = desired;
        next_level = step_toward(level, desired);
        next_cnt = {CNT_W{1'b0}};
        next_busy = (step_toward(level, desired) != desired);
      end
    end else if (interval_done) begin
      next_level = step_toward(level, run_goal);
      next_cnt = {CNT_W{1'b0}};
      next_busy = (step_toward(level, run_goal) != run_goal);
    end else begin
      // A new target waits here until the running ramp ends.
      next_cnt = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      level <= `LLR_CODE_ZERO;
      goal <= `LLR_CODE_ZERO;
      cnt <= {CNT_W{1'b0}};
      busy <= 1'b0;
      sink_hiz <= 1'b1;
    end else if (clear) begin
      level <= `LLR_CODE_ZERO;
      goal <= `LLR_CODE_ZERO;
      cnt <= {CNT_W{1'b0}};
      busy <= 1'b0;
      sink_hiz <= 1'b1;
    end else begin
      level <= next_level;
      goal <= next_goal;
      cnt <= next_cnt;
      busy <= next_busy;
      // The sink floats only once it is off and the fade has reached zero.
      sink_hiz <= !sink_on && (next_level == `LLR_CODE_ZERO);
    end
  end

endmodule // llr_ramp_channel
`default_nettype wire

// ### logic/llr_top.v
// Behaviour
// - Rate bits select 51us, 13ms, 26ms, 52ms steps.
// - Level changes ramp; only a low reset pin jumps the sink to zero.
// - One code per interval, each held fully; a waiting target leaves a ramp's last code after one cycle.
// - Switching on ramps upward from zero.
// - New target waits until current ramp completes.
// - Then ramp up or down to latest target.
// - Rate change applies immediately to remaining steps.
// - Pin function clear: pin is active-low reset.
// - Enabled, direction clear: pin is logic input.
// - Output mode: data 0 low, 1 released.
// - Primary enable 0 turns primary sink off.
// - Secondary enable 0 turns secondary sink off outside unison mode.
// - Enable 1 turns sink on at level; secondary enable counts only outside unison and voltage output mode.
// - Only five low level bits are used.
// - Unison mode drives both sinks from primary unless voltage output mode holds secondary off.
// - First step is immediate, then one interval each.
// - Switching off mid-ramp fades down at rate.
`timescale 1ns/10ps
`default_nettype none
`include "llr_defines.vh"

module llr_top #(
  parameter CNT_W = `LLR_CNT_W,
  parameter [`LLR_CNT_W-1:0] STEP0_CYCLES = `LLR_STEP0_CYCLES,
  parameter [`LLR_CNT_W-1:0] STEP1_CYCLES = `LLR_STEP1_CYCLES,
  parameter [`LLR_CNT_W-1:0] STEP2_CYCLES = `LLR_STEP2_CYCLES,
  parameter [`LLR_CNT_W-1:0] STEP3_CYCLES = `LLR_STEP3_CYCLES
) (
  input wire CORE_CLK,
  input wire ARST_N,
  input wire RAMP_RATE_BIT_A,
  input wire RAMP_RATE_BIT_B,
  input wire [7:0] PRIMARY_LEVEL_CODE,
  input wire [7:0] SECONDARY_LEVEL_CODE,
  input wire PRIMARY_SINK_ON,
  input wire SECONDARY_SINK_ON,
  input wire SHARED_LEVEL_SELECT,
  input wire VOLTAGE_OUTPUT_MODE,
  input wire [7:0] SHARED_PIN_CONTROL,
  input wire SHARED_PIN_IN,
  output reg SHARED_PIN_OUT,
  output reg SHARED_PIN_OE,
  output reg [7:0] SHARED_PIN_READ,
  output reg DEVICE_RESET_N,
  output wire [4:0] PRIMARY_APPLIED_CODE,
  output wire PRIMARY_SINK_HIZ,
  output wire PRIMARY_RAMP_BUSY,
  output wire [4:0] SECONDARY_APPLIED_CODE,
  output wire SECONDARY_SINK_HIZ,
  output wire SECONDARY_RAMP_BUSY
);

  // ******************************************************************
  // Host field capture
  // ******************************************************************

  // The host side writes these fields on its own timing. A field set is
  // taken only after it has been stable for a full cycle past the
  // synchroniser, so a half-finished write never reaches a sink.
  wire [`LLR_HV_W-1:0] host_raw;
  reg [`LLR_HV_W-1:0] host_meta;
  reg [`LLR_HV_W-1:0] host_sync;
  reg [`LLR_HV_W-1:0] host_prev;
  reg [`LLR_HV_W-1:0] host_live;

  assign host_raw = {SHARED_PIN_CONTROL[2:0], VOLTAGE_OUTPUT_MODE, SHARED_LEVEL_SELECT,
                     SECONDARY_SINK_ON, PRIMARY_SINK_ON, SECONDARY_LEVEL_CODE[4:0],
                     PRIMARY_LEVEL_CODE[4:0], RAMP_RATE_BIT_A, RAMP_RATE_BIT_B};

  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      host_meta <= `LLR_HV_RESET;
      host_sync <= `LLR_HV_RESET;
      host_prev <= `LLR_HV_RESET;
      host_live <= `LLR_HV_RESET;
    end else begin
      host_meta <= host_raw;
      host_sync <= host_meta;
      host_prev <= host_sync;
      if (host_sync == host_prev) begin
        host_live <= host_sync;
      end
    end
  end

  // ******************************************************************
  // Field decode
  // ******************************************************************

  wire [1:0] rate_sel;
  wire [4:0] pcode;
  wire [4:0] scode;
  wire pon;
  wire son;
  wire shared_level_select;
  wire vmode;
  wire pin_en;
  wire pin_dir;
  wire pin_data;

  assign rate_sel = host_live[`LLR_HV_RATE_LO +: 2];
  assign pcode = host_live[`LLR_HV_PCODE_LO +: 5];
  assign scode = host_live[`LLR_HV_SCODE_LO +: 5];
  assign pon = host_live[`LLR_HV_PON];
  assign son = host_live[`LLR_HV_SON];
  assign shared_level_select = host_live[`LLR_HV_UNI];
  assign vmode = host_live[`LLR_HV_VMODE];
  assign pin_en = host_live[`LLR_HV_PIN_LO + `LLR_PIN_EN_BIT];
  assign pin_dir = host_live[`LLR_HV_PIN_LO + `LLR_PIN_DIR_BIT];
  assign pin_data = host_live[`LLR_HV_PIN_LO + `LLR_PIN_DATA_BIT];

  // ******************************************************************
  // Step interval select
  // ******************************************************************

  function [`LLR_CNT_W-1:0] interval_cycles;
    input [1:0] sel;
    begin
      if (sel == `LLR_RATE_51US) begin
        interval_cycles = STEP0_CYCLES;
      end else if (sel == `LLR_RATE_13MS) begin
        interval_cycles = STEP1_CYCLES;
      end else if (sel == `LLR_RATE_26MS) begin
        interval_cycles = STEP2_CYCLES;
      end else begin
        interval_cycles = STEP3_CYCLES;
      end
    end
  endfunction

  // Shared by both sinks; a shortened simulation value below one cycle
  // is lifted to one so a step never becomes free.
  wire [CNT_W-1:0] step_limit_raw;
  wire [CNT_W-1:0] step_limit;

  assign step_limit_raw = interval_cycles(rate_sel);
  assign step_limit = (step_limit_raw == {CNT_W{1'b0}}) ? {{(CNT_W-1){1'b0}}, 1'b1} : step_limit_raw;

  // ******************************************************************
  // Shared pin
  // ******************************************************************

  reg pin_meta;
  reg pin_sync;

  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      pin_meta <= SHARED_PIN_IN;
      pin_sync <= pin_meta;
    end
  end

  // The pin is open-drain: it is only ever pulled low, never driven high.
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SHARED_PIN_OUT <= 1'b0;
      SHARED_PIN_OE <= 1'b0;
      DEVICE_RESET_N <= 1'b1;
      SHARED_PIN_READ <= `LLR_PIN_CTRL_RESET;
    end else begin
      SHARED_PIN_OUT <= 1'b0;
      SHARED_PIN_OE <= pin_en && pin_dir && !pin_data;
      DEVICE_RESET_N <= pin_en || pin_sync;
      SHARED_PIN_READ <= {5'h00, pin_sync, pin_dir, pin_en};
    end
  end

  // A low reset level on the pin returns both sinks to zero at once.
  wire ramp_clear;

  assign ramp_clear = !DEVICE_RESET_N;

  // ******************************************************************
  // Sink routing
  // ******************************************************************

  // Unison ties the secondary sink to the primary code and enable. In
  // voltage output mode the secondary pin is feedback, so its sink stays off.
  wire [1:0] ch_on;
  wire [9:0] ch_target;
  wire [9:0] ch_level;
  wire [1:0] ch_busy;
  wire [1:0] ch_hiz;

  assign ch_on[0] = pon;
  assign ch_on[1] = !vmode && (shared_level_select ? pon : son);
  assign ch_target[4:0] = pcode;
  assign ch_target[9:5] = shared_level_select ? pcode : scode;

  // ******************************************************************
  // Ramp channels
  // ******************************************************************

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sink
      llr_ramp_channel #(
        .CNT_W(CNT_W)
      ) u_ramp (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .clear(ramp_clear),
        .sink_on(ch_on[gi]),
        .target(ch_target[gi*5 +: 5]),
        .step_limit(step_limit),
        .level(ch_level[gi*5 +: 5]),
        .busy(ch_busy[gi]),
        .sink_hiz(ch_hiz[gi])
      );
    end
  endgenerate

  assign PRIMARY_APPLIED_CODE = ch_level[4:0];
  assign PRIMARY_SINK_HIZ = ch_hiz[0];
  assign PRIMARY_RAMP_BUSY = ch_busy[0];
  assign SECONDARY_APPLIED_CODE = ch_level[9:5];
  assign SECONDARY_SINK_HIZ = ch_hiz[1];
  assign SECONDARY_RAMP_BUSY = ch_busy[1];

endmodule // llr_top
`default_nettype wire

// ### tb/llr_checker.sv
`timescale 1ns/10ps
`default_nettype none
module llr_checker (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] SHARED_PIN_CONTROL,
  input wire logic SHARED_PIN_IN,
  input wire logic SHARED_PIN_OUT,
  input wire logic SHARED_PIN_OE,
  input wire logic [7:0] SHARED_PIN_READ,
  input wire logic DEVICE_RESET_N,
  input wire logic [4:0] PRIMARY_APPLIED_CODE,
  input wire logic PRIMARY_SINK_HIZ,
  input wire logic PRIMARY_RAMP_BUSY,
  input wire logic [4:0] SECONDARY_APPLIED_CODE,
  input wire logic SECONDARY_SINK_HIZ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // Six samples cover the synchroniser, the settle compare and the capture.
  sequence s_held(logic [2:0] v);
    (SHARED_PIN_CONTROL[2:0] == v) [*6];
  endsequence
  chk_pin_drive: assert property (s_held(3'h3) |-> SHARED_PIN_OE && !SHARED_PIN_OUT)
    else $error("shared pin not pulled low");
  chk_pin_release: assert property (s_held(3'h7) |-> !SHARED_PIN_OE)
    else $error("shared pin not released");
  chk_reset_input: assert property ((!SHARED_PIN_CONTROL[0] && !SHARED_PIN_IN) [*6] |-> !DEVICE_RESET_N)
    else $error("low reset pin ignored");
  chk_read_level: assert property ($stable(SHARED_PIN_IN) [*5] |-> SHARED_PIN_READ[2] == SHARED_PIN_IN)
    else $error("pin level not readable");
  chk_pri_step: assert property ($changed(PRIMARY_APPLIED_CODE)
    |-> (PRIMARY_APPLIED_CODE - $past(PRIMARY_APPLIED_CODE)) inside {5'h01, 5'h1F})
    else $error("primary code jumped");
  chk_sec_step: assert property ($changed(SECONDARY_APPLIED_CODE)
    |-> (SECONDARY_APPLIED_CODE - $past(SECONDARY_APPLIED_CODE)) inside {5'h01, 5'h1F})
    else $error("secondary code jumped");
  chk_pri_hold: assert property ($changed(PRIMARY_APPLIED_CODE) && PRIMARY_RAMP_BUSY
    |=> $stable(PRIMARY_APPLIED_CODE) [*2])
    else $error("primary code not held");
  chk_pri_hiz: assert property (PRIMARY_SINK_HIZ |-> PRIMARY_APPLIED_CODE == 5'h00)
    else $error("primary off with current");
  chk_sec_hiz: assert property (SECONDARY_SINK_HIZ |-> SECONDARY_APPLIED_CODE == 5'h00)
    else $error("secondary off with current");
endmodule // llr_checker
bind llr_top llr_checker llr_checker_inst (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N),
  .SHARED_PIN_CONTROL(SHARED_PIN_CONTROL), .SHARED_PIN_IN(SHARED_PIN_IN), .SHARED_PIN_OUT(SHARED_PIN_OUT),
  .SHARED_PIN_OE(SHARED_PIN_OE), .SHARED_PIN_READ(SHARED_PIN_READ), .DEVICE_RESET_N(DEVICE_RESET_N),
  .PRIMARY_APPLIED_CODE(PRIMARY_APPLIED_CODE), .PRIMARY_SINK_HIZ(PRIMARY_SINK_HIZ),
  .PRIMARY_RAMP_BUSY(PRIMARY_RAMP_BUSY), .SECONDARY_APPLIED_CODE(SECONDARY_APPLIED_CODE),
  .SECONDARY_SINK_HIZ(SECONDARY_SINK_HIZ));
`default_nettype wire

// ### tb/llr_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module llr_pin_model (
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic ext_low,
  output logic pin
);
  // The board pull-up holds the line high unless the block or an outside part sinks it.
  assign pin = ((pin_oe && !pin_out) || ext_low) ? 1'b0 : 1'b1;
endmodule // llr_pin_model
`default_nettype wire

// ### tb/test_llr_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_llr_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] rate = 2'h0;
  logic [7:0] pcode = 8'h00, scode = 8'h00, pctl = 8'h00;
  logic pon = 1'b0, son = 1'b0, shared_level_select = 1'b0, vmode = 1'b0, ext_low = 1'b0;
  wire logic pin, pin_out, pin_oe, dev_rst_n, phiz, pbusy, shiz, sbusy;
  wire logic [7:0] pin_read;
  wire logic [4:0] pcur, scur;
  int n_fail = 0;
  int total_checks = 0;
  // Short step counts keep the run brief; gaps are 4, 8, 12 and 16 cycles.
  llr_top #(.STEP0_CYCLES(23'h4), .STEP1_CYCLES(23'h8), .STEP2_CYCLES(23'hC), .STEP3_CYCLES(23'h10)) llr_top_inst (
    .CORE_CLK(clk), .ARST_N(arst_n), .RAMP_RATE_BIT_A(rate[1]), .RAMP_RATE_BIT_B(rate[0]),
    .PRIMARY_LEVEL_CODE(pcode), .SECONDARY_LEVEL_CODE(scode), .PRIMARY_SINK_ON(pon), .SECONDARY_SINK_ON(son),
    .SHARED_LEVEL_SELECT(shared_level_select), .VOLTAGE_OUTPUT_MODE(vmode), .SHARED_PIN_CONTROL(pctl), .SHARED_PIN_IN(pin),
    .SHARED_PIN_OUT(pin_out), .SHARED_PIN_OE(pin_oe), .SHARED_PIN_READ(pin_read), .DEVICE_RESET_N(dev_rst_n),
    .PRIMARY_APPLIED_CODE(pcur), .PRIMARY_SINK_HIZ(phiz), .PRIMARY_RAMP_BUSY(pbusy),
    .SECONDARY_APPLIED_CODE(scur), .SECONDARY_SINK_HIZ(shiz), .SECONDARY_RAMP_BUSY(sbusy));
  llr_pin_model llr_pin_model_inst (.pin_oe(pin_oe), .pin_out(pin_out), .ext_low(ext_low), .pin(pin));
  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic put(input logic [1:0] r, input logic [7:0] p, input logic [7:0] s, input logic [3:0] m);
    @(posedge clk);
    rate <= r;
    pcode <= p;
    scode <= s;
    {vmode, shared_level_select, son, pon} <= m;
  endtask
  // Walks a ramp to its end and measures every gap after the first seen step.
  task automatic follow(input logic ch, input logic [4:0] fin, input int len);
    logic [4:0] last;
    int gap;
    bit first;
    #1;
    last = ch ? scur : pcur;
    gap = 0;
    first = 1'b1;
    while ((ch ? scur : pcur) !== fin || (ch ? sbusy : pbusy) !== 1'b0) begin
      @(posedge clk);
      #1;
      gap++;
      if ((ch ? scur : pcur) !== last) begin
        if (!first) check(8'(gap), 8'(len), "step gap");
        first = 1'b0;
        gap = 0;
        last = ch ? scur : pcur;
      end
      if (gap > 400) begin
        check(8'h00, 8'h01, "ramp stalled");
        break;
      end
    end
  endtask
  task automatic pin_set(input logic [7:0] c, input logic lo, input logic [7:0] rd, input logic oe);
    @(posedge clk);
    pctl <= c;
    ext_low <= lo;
    repeat (8) @(posedge clk);
    #1;
    check(pin_read, rd, "pin read");
    check({7'h00, pin_oe}, {7'h00, oe}, "pin drive");
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    #400000;
    n_fail++;
    give_verdict();
  end
  initial begin
    @(posedge clk);
    #1;
    check({1'b0, pcur, phiz, pbusy}, 8'h02, "reset state");
    check(pin_read, 8'h00, "reset read");
    @(posedge clk);
    arst_n <= 1'b1;
    put(2'h0, 8'hE3, 8'h00, 4'h1);
    follow(1'b0, 5'h03, 4);
    for (int r = 1; r < 4; r++) begin
      put(2'(r), 8'(3 + 2 * r), 8'h00, 4'h1);
      follow(1'b0, 5'(3 + 2 * r), 4 * (r + 1));
    end
    put(2'h3, 8'h14, 8'h00, 4'h1);
    repeat (40) @(posedge clk);
    put(2'h0, 8'h14, 8'h00, 4'h1);
    repeat (6) @(posedge clk);
    follow(1'b0, 5'h14, 4);
    put(2'h0, 8'h1F, 8'h00, 4'h1);
    repeat (12) @(posedge clk);
    put(2'h0, 8'h09, 8'h00, 4'h1);
    follow(1'b0, 5'h1F, 4);
    follow(1'b0, 5'h09, 4);
    put(2'h0, 8'h1F, 8'h00, 4'h1);
    repeat (12) @(posedge clk);
    put(2'h0, 8'h1F, 8'h00, 4'h0);
    follow(1'b0, 5'h00, 4);
    check({7'h00, phiz}, 8'h01, "primary off");
    put(2'h0, 8'h05, 8'h1F, 4'h1);
    follow(1'b0, 5'h05, 4);
    put(2'h0, 8'h05, 8'h1F, 4'h5);
    follow(1'b1, 5'h05, 4);
    put(2'h0, 8'h05, 8'h02, 4'h3);
    follow(1'b1, 5'h02, 4);
    put(2'h0, 8'h05, 8'h02, 4'h1);
    follow(1'b1, 5'h00, 4);
    check({7'h00, shiz}, 8'h01, "secondary off");
    put(2'h0, 8'h05, 8'h03, 4'hB);
    repeat (20) @(posedge clk);
    #1;
    check({2'b00, scur, shiz}, 8'h01, "feedback mode");
    put(2'h0, 8'h05, 8'h02, 4'h0);
    follow(1'b0, 5'h00, 4);
    pin_set(8'h03, 1'b0, 8'h03, 1'b1);
    pin_set(8'hFF, 1'b0, 8'h07, 1'b0);
    pin_set(8'h01, 1'b1, 8'h01, 1'b0);
    pin_set(8'h01, 1'b0, 8'h05, 1'b0);
    pin_set(8'h00, 1'b1, 8'h00, 1'b0);
    check({7'h00, dev_rst_n}, 8'h00, "reset pin low");
    pin_set(8'h00, 1'b0, 8'h04, 1'b0);
    check({7'h00, dev_rst_n}, 8'h01, "reset pin high");
    give_verdict();
  end
endmodule // test_llr_top
`default_nettype wire
